// ==== inc/sdpr_params.svh ====
// Constants for the synchronous dual-port RAM port logic.
// Assumes both masters share one clock and keep their inputs stable around its edge.
// Operation
// - 64K x 18 words, both ports reach any word
// - Each port captures inputs on rising edge
// - All control but output enable, address, data inputs registered
// - Deselect: no access, lanes float, standby
// - Upper lane bits 9-17, lower 0-8
// - Upper-only write leaves lower byte intact
// - Lower select low writes lower lane
// - Read drives selected lanes, others float
// - Output enable acts asynchronously, floats lanes
// - Flow-through or one extra pipelined cycle
// - Latency chosen per port by own input
// - Clear sets counter to zero, accesses zero
// - Load strobe uses external address
// - Load strobe ignores chip and lane selects
// - All high: reuse previous address
// - Increment enable low: previous address plus one
// - Counter advances even when deselected
`ifndef SDPR_PARAMS_SVH
`define SDPR_PARAMS_SVH

`define SDPR_NPORT      2
`define SDPR_ADDR_W     16
`define SDPR_DATA_W     18
`define SDPR_LANE_W     9
`define SDPR_UPPER_LSB  9
`define SDPR_UPPER_MSB  17
`define SDPR_LOWER_LSB  0
`define SDPR_LOWER_MSB  8
`define SDPR_ADDR_ZERO  16'h0000
`define SDPR_DATA_ZERO  18'h0_0000
`define SDPR_ADDR_ONE   16'h0001

`endif

// ==== inc/sdpr_pkg.sv ====
// Types shared by the dual-port RAM port logic.
// Assumes sdpr_params.svh is on the include path.
`include "sdpr_params.svh"

package sdpr_pkg;

	typedef enum logic
	{
		SDPR_FLOW = 1'b0,
		SDPR_PIPE = 1'b1
	} sdpr_lat_t;

	typedef logic [`SDPR_ADDR_W-1:0] sdpr_addr_t;
	typedef logic [`SDPR_DATA_W-1:0] sdpr_data_t;

endpackage

// ==== rtl/sdpr_port.sv ====
// Dual-port 64K x 18 synchronous RAM with per-port address counters and output latency.
// Assumes both masters run on clk and drive inputs by non-blocking assignment after its edge;
// the data pins are split into in, out and per-lane enable, resolved outside.
`timescale 1ns/100ps
`include "sdpr_params.svh"

module sdpr_port
	import sdpr_pkg::*;
#(
	parameter int NPORT  = `SDPR_NPORT,
	parameter int ADDR_W = `SDPR_ADDR_W,
	parameter int DATA_W = `SDPR_DATA_W
)
(
	input  wire logic                          clk,                  // Common clock
	input  wire logic                          rstn,                 // Sync reset, active low
	input  wire logic [NPORT-1:0]              selectActiveLow,      // Chip select, active low
	input  wire logic [NPORT-1:0]              selectActiveHigh,     // Chip select, active high
	input  wire logic [NPORT-1:0]              readNotWrite,         // High read, low write
	input  wire logic [NPORT-1:0]              outputEnable_n,       // Async output enable
	input  wire logic [NPORT-1:0]              upperLaneSelect_n,    // Upper lane select
	input  wire logic [NPORT-1:0]              lowerLaneSelect_n,    // Lower lane select
	input  wire logic [NPORT-1:0]              addressLoadStrobe_n,  // Load external address
	input  wire logic [NPORT-1:0]              incrementEnable_n,    // Counter increment
	input  wire logic [NPORT-1:0]              counterClear_n,       // Counter clear
	input  wire logic [NPORT-1:0]              outputLatencySelect,  // 1 pipelined, 0 flow
	input  wire logic [NPORT-1:0][ADDR_W-1:0]  addrIn,               // External address
	input  wire logic [NPORT-1:0][DATA_W-1:0]  dataIn,               // Data pin level
	output logic      [NPORT-1:0][DATA_W-1:0]  dataOut,              // Read data
	output logic      [NPORT-1:0]              dataOeUpper,          // Drive bits 17..9
	output logic      [NPORT-1:0]              dataOeLower,          // Drive bits 8..0
	output logic      [NPORT-1:0]              standby               // Port in power down
);

	// Shared array; only the tail of the writer loop decides a collision
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	logic [NPORT-1:0][ADDR_W-1:0] addr_r;
	logic [NPORT-1:0][ADDR_W-1:0] addrNxt;
	logic [NPORT-1:0][DATA_W-1:0] wdata_r;
	logic [NPORT-1:0]             wrUp_r;
	logic [NPORT-1:0]             wrLo_r;
	logic [NPORT-1:0]             rdUp_r;
	logic [NPORT-1:0]             rdLo_r;
	logic [NPORT-1:0]             pipe_r;
	logic [NPORT-1:0]             standby_r;
	logic [NPORT-1:0][DATA_W-1:0] pipeData_r;
	logic [NPORT-1:0]             pipeUp_r;
	logic [NPORT-1:0]             pipeLo_r;
	logic [NPORT-1:0][DATA_W-1:0] dout_r;
	logic [NPORT-1:0]             oeUp_r;
	logic [NPORT-1:0]             oeLo_r;
	logic [NPORT-1:0][DATA_W-1:0] memRead;
	logic [NPORT-1:0]             selected;
	logic [NPORT-1:0]             wrUpNxt;
	logic [NPORT-1:0]             wrLoNxt;
	logic [NPORT-1:0]             rdUpNxt;
	logic [NPORT-1:0]             rdLoNxt;

	// Port with the highest index wins a same-word write collision
	always_ff @(posedge clk)
	begin
		for (int p = 0; p < NPORT; p++)
		begin
			if (wrUp_r[p])
				mem[addr_r[p]][`SDPR_UPPER_MSB:`SDPR_UPPER_LSB] <=
					wdata_r[p][`SDPR_UPPER_MSB:`SDPR_UPPER_LSB];
			if (wrLo_r[p])
				mem[addr_r[p]][`SDPR_LOWER_MSB:`SDPR_LOWER_LSB] <=
					wdata_r[p][`SDPR_LOWER_MSB:`SDPR_LOWER_LSB];
		end
	end

	// Per-port decode, counter and read pipeline
	genvar i;
	generate
		for (i = 0; i < NPORT; i++)
		begin : g_port
			assign selected[i] = ~selectActiveLow[i] & selectActiveHigh[i];
			assign wrUpNxt[i]  = selected[i] & ~readNotWrite[i] & ~upperLaneSelect_n[i];
			assign wrLoNxt[i]  = selected[i] & ~readNotWrite[i] & ~lowerLaneSelect_n[i];
			assign rdUpNxt[i]  = selected[i] & readNotWrite[i] & ~upperLaneSelect_n[i];
			assign rdLoNxt[i]  = selected[i] & readNotWrite[i] & ~lowerLaneSelect_n[i];

			// Counter runs whatever the selects say, so bursts keep their place
			assign addrNxt[i] =
				!counterClear_n[i]      ? `SDPR_ADDR_ZERO :
				!addressLoadStrobe_n[i] ? addrIn[i] :
				!incrementEnable_n[i]   ? addr_r[i] + `SDPR_ADDR_ONE :
				addr_r[i];

			assign memRead[i] = mem[addr_r[i]];

			// Input registers: the access runs one edge after capture
			always_ff @(posedge clk)
			begin
				if (!rstn)
					addr_r[i] <= `SDPR_ADDR_ZERO;
				else
					addr_r[i] <= addrNxt[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					wdata_r[i] <= `SDPR_DATA_ZERO;
				else
					wdata_r[i] <= dataIn[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					wrUp_r[i] <= 1'b0;
				else
					wrUp_r[i] <= wrUpNxt[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					wrLo_r[i] <= 1'b0;
				else
					wrLo_r[i] <= wrLoNxt[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					rdUp_r[i] <= 1'b0;
				else
					rdUp_r[i] <= rdUpNxt[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					rdLo_r[i] <= 1'b0;
				else
					rdLo_r[i] <= rdLoNxt[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					pipe_r[i] <= 1'b0;
				else
					pipe_r[i] <= outputLatencySelect[i];
			end

			// Reset leaves the port powered down until the first select
			always_ff @(posedge clk)
			begin
				if (!rstn)
					standby_r[i] <= 1'b1;
				else
					standby_r[i] <= ~selected[i];
			end

			// Output stage; pipelined mode takes the copy held one cycle longer
			always_ff @(posedge clk)
			begin
				if (!rstn)
					pipeData_r[i] <= `SDPR_DATA_ZERO;
				else
					pipeData_r[i] <= memRead[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					pipeUp_r[i] <= 1'b0;
				else
					pipeUp_r[i] <= rdUp_r[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					pipeLo_r[i] <= 1'b0;
				else
					pipeLo_r[i] <= rdLo_r[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					dout_r[i] <= `SDPR_DATA_ZERO;
				else
					dout_r[i] <= pipe_r[i] ? pipeData_r[i] : memRead[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					oeUp_r[i] <= 1'b0;
				else
					oeUp_r[i] <= pipe_r[i] ? pipeUp_r[i] : rdUp_r[i];
			end

			always_ff @(posedge clk)
			begin
				if (!rstn)
					oeLo_r[i] <= 1'b0;
				else
					oeLo_r[i] <= pipe_r[i] ? pipeLo_r[i] : rdLo_r[i];
			end

			assign dataOut[i] = dout_r[i];
			assign standby[i] = standby_r[i];
			// Gate is outside the flops on purpose: disable must not wait for clk
			assign dataOeUpper[i] = oeUp_r[i] & ~outputEnable_n[i];
			assign dataOeLower[i] = oeLo_r[i] & ~outputEnable_n[i];

			a_clear_to_zero: assert property (@(posedge clk) disable iff (!rstn)
				!counterClear_n[i] |=> addr_r[i] == `SDPR_ADDR_ZERO)
				else $error("counter clear did not reach zero");

			a_load_ext_addr: assert property (@(posedge clk) disable iff (!rstn)
				(counterClear_n[i] && !addressLoadStrobe_n[i]) |=> addr_r[i] == $past(addrIn[i]))
				else $error("external address not loaded");

			a_hold_prev_addr: assert property (@(posedge clk) disable iff (!rstn)
				(counterClear_n[i] && addressLoadStrobe_n[i] && incrementEnable_n[i])
				|=> $stable(addr_r[i]))
				else $error("held address changed");

			a_incr_wraps: assert property (@(posedge clk) disable iff (!rstn)
				(counterClear_n[i] && addressLoadStrobe_n[i] && !incrementEnable_n[i])
				|=> addr_r[i] == ADDR_W'($past(addr_r[i]) + `SDPR_ADDR_ONE))
				else $error("counter did not advance by one");

			a_desel_floats: assert property (@(posedge clk) disable iff (!rstn)
				(!selected[i] && !outputLatencySelect[i])
				|=> standby_r[i] ##1 (!oeUp_r[i] && !oeLo_r[i]))
				else $error("deselected port drove a lane");

			a_ft_read_drive: assert property (@(posedge clk) disable iff (!rstn)
				(rdUpNxt[i] && !rdLoNxt[i] && !outputLatencySelect[i])
				|=> ##1 (oeUp_r[i] && !oeLo_r[i]))
				else $error("flow-through read lanes wrong");

			a_pipe_extra_cycle: assert property (@(posedge clk) disable iff (!rstn)
				(rdLoNxt[i] && outputLatencySelect[i]) ##1 outputLatencySelect[i]
				|=> ##1 oeLo_r[i])
				else $error("pipelined read not driven after extra cycle");

			a_oe_async_off: assert property (@(posedge clk) disable iff (!rstn)
				outputEnable_n[i] |-> (!dataOeUpper[i] && !dataOeLower[i]))
				else $error("lane driven while output enable high");

			// Enable must pass straight through while outputs are on
			a_oe_follows: assert property (@(posedge clk) disable iff (!rstn)
				!outputEnable_n[i] |-> (dataOeUpper[i] == oeUp_r[i] && dataOeLower[i] == oeLo_r[i]))
				else $error("lane enable blocked while outputs on");

			// Select and lane decode, seen one edge later in the flags
			a_desel_no_write: assert property (@(posedge clk) disable iff (!rstn)
				!selected[i] |=> (!wrUp_r[i] && !wrLo_r[i] && !rdUp_r[i] && !rdLo_r[i]))
				else $error("deselected port started an access");

			a_lanes_off_idle: assert property (@(posedge clk) disable iff (!rstn)
				(selected[i] && upperLaneSelect_n[i] && lowerLaneSelect_n[i])
				|=> (!wrUp_r[i] && !wrLo_r[i] && !rdUp_r[i] && !rdLo_r[i]))
				else $error("access with both lanes off");

			a_write_no_drive: assert property (@(posedge clk) disable iff (!rstn)
				(selected[i] && !readNotWrite[i]) |=> (!rdUp_r[i] && !rdLo_r[i]))
				else $error("write cycle armed a lane drive");

			a_read_no_write: assert property (@(posedge clk) disable iff (!rstn)
				(selected[i] && readNotWrite[i]) |=> (!wrUp_r[i] && !wrLo_r[i]))
				else $error("read cycle armed a lane write");

			a_standby_clear: assert property (@(posedge clk) disable iff (!rstn)
				selected[i] |=> !standby_r[i])
				else $error("selected port left in standby");

			// Counter keeps its place on deselected cycles too
			a_count_desel: assert property (@(posedge clk) disable iff (!rstn)
				(!selected[i] && counterClear_n[i] && addressLoadStrobe_n[i]
					&& !incrementEnable_n[i])
				|=> addr_r[i] == ADDR_W'($past(addr_r[i]) + `SDPR_ADDR_ONE))
				else $error("counter stalled while deselected");

			a_load_desel: assert property (@(posedge clk) disable iff (!rstn)
				(!selected[i] && counterClear_n[i] && !addressLoadStrobe_n[i])
				|=> addr_r[i] == $past(addrIn[i]))
				else $error("load strobe ignored while deselected");

			a_clear_over_load: assert property (@(posedge clk) disable iff (!rstn)
				(!counterClear_n[i] && !addressLoadStrobe_n[i]) |=> addr_r[i] == `SDPR_ADDR_ZERO)
				else $error("load strobe beat counter clear");

			// Read data checked against the word addressed at capture
			a_flow_data: assert property (@(posedge clk) disable iff (!rstn)
				(rdLoNxt[i] && !outputLatencySelect[i])
				|=> ##1 dout_r[i] == $past(memRead[i]))
				else $error("flow-through data not from addressed word");

			a_pipe_data: assert property (@(posedge clk) disable iff (!rstn)
				(rdLoNxt[i] && outputLatencySelect[i]) ##1 outputLatencySelect[i]
				|=> ##1 dout_r[i] == $past(memRead[i], 2))
				else $error("pipelined data not from addressed word");

			c_desel_count: cover property (@(posedge clk) disable iff (!rstn)
				!selected[i] && !incrementEnable_n[i] ##1 selected[i]);

			c_ft_read: cover property (@(posedge clk) disable iff (!rstn)
				rdUpNxt[i] && rdLoNxt[i] && !outputLatencySelect[i] ##2 dataOeUpper[i]);

			c_pipe_read: cover property (@(posedge clk) disable iff (!rstn)
				rdLoNxt[i] && outputLatencySelect[i] ##1 outputLatencySelect[i] ##2 dataOeLower[i]);

			c_wrap: cover property (@(posedge clk) disable iff (!rstn)
				&addr_r[i] && counterClear_n[i] && addressLoadStrobe_n[i] && !incrementEnable_n[i]);
		end
	endgenerate

	a_write_last_port: assert property (@(posedge clk) disable iff (!rstn)
		wrUpNxt[NPORT-1] |=> ##1 mem[$past(addr_r[NPORT-1])][`SDPR_UPPER_MSB:`SDPR_UPPER_LSB]
			== $past(wdata_r[NPORT-1][`SDPR_UPPER_MSB:`SDPR_UPPER_LSB]))
		else $error("upper lane write not stored");

	// Lower lane mirrors the upper-lane check on the same port
	a_write_lower_lane: assert property (@(posedge clk) disable iff (!rstn)
		wrLoNxt[NPORT-1] |=> ##1 mem[$past(addr_r[NPORT-1])][`SDPR_LOWER_MSB:`SDPR_LOWER_LSB]
			== $past(wdata_r[NPORT-1][`SDPR_LOWER_MSB:`SDPR_LOWER_LSB]))
		else $error("lower lane write not stored");

	// Upper-only write must leave the lower lane as it was
	a_upper_keeps_lower: assert property (@(posedge clk) disable iff (!rstn)
		(wrUpNxt[NPORT-1] && wrLoNxt == '0)
		|=> ##1 mem[$past(addr_r[NPORT-1])][`SDPR_LOWER_MSB:`SDPR_LOWER_LSB]
			== $past(mem[addr_r[NPORT-1]][`SDPR_LOWER_MSB:`SDPR_LOWER_LSB]))
		else $error("upper-only write disturbed lower lane");

	// Same-word collision; the highest-index port wins, not checked here
	c_same_word: cover property (@(posedge clk) disable iff (!rstn)
		wrUp_r[0] && wrUp_r[NPORT-1] && addr_r[0] == addr_r[NPORT-1]);

endmodule

// ==== tb/sdpr_masters.sv ====
// Behavioural masters on both ports, plus resolution of the data pins.
// Assumes the bench calls cyc at most once per cycle for each port.
`timescale 1ns/100ps
module sdpr_masters
	import sdpr_pkg::*;
(
	input  wire logic [1:0]       clk,                 // Clock
	input  wire logic [1:0][17:0] dataOut,             // Device read data
	input  wire logic [1:0]       dataOeUpper,         // Device drives 17..9
	input  wire logic [1:0]       dataOeLower,         // Device drives 8..0
	output logic      [1:0]       selectActiveLow,     // Select, low
	output logic      [1:0]       selectActiveHigh,    // Select, high
	output logic      [1:0]       readNotWrite,        // Read high
	output logic      [1:0]       outputEnable_n,      // Output enable
	output logic      [1:0]       upperLaneSelect_n,   // Upper lane
	output logic      [1:0]       lowerLaneSelect_n,   // Lower lane
	output logic      [1:0]       addressLoadStrobe_n, // Load address
	output logic      [1:0]       incrementEnable_n,   // Count up
	output logic      [1:0]       counterClear_n,      // Clear count
	output logic      [1:0]       outputLatencySelect, // Pipelined
	output logic      [1:0][15:0] addrIn,              // Address
	output logic      [1:0][17:0] dataIn               // Pin level
);
	sdpr_data_t wData [2];
	sdpr_data_t noise;

	task automatic put(input int p, input logic [8:0] c, input sdpr_addr_t a, input sdpr_data_t d);
		{selectActiveLow[p], selectActiveHigh[p], readNotWrite[p], upperLaneSelect_n[p],
			lowerLaneSelect_n[p], addressLoadStrobe_n[p], incrementEnable_n[p],
			counterClear_n[p], outputLatencySelect[p]} <= c;
		addrIn[p] <= a;
		wData[p] <= d;
	endtask

	// Changes only just after the edge, held for the whole cycle
	task automatic cyc(input int p, input logic [8:0] c, input sdpr_addr_t a, input sdpr_data_t d);
		@(posedge clk[0]);
		put(p, c, a, d);
	endtask

	task automatic oe(input int p, input logic v);
		@(posedge clk[0]);
		outputEnable_n[p] <= v;
	endtask

	initial
	begin
		outputEnable_n = 2'h0;
		noise = 18'h2_AAAA;
		put(0, 9'h0FE, 16'h0000, 18'h0_0000);
		put(1, 9'h0FE, 16'h0000, 18'h0_0000);
	end

	// A released pin must not keep its last value
	always @(posedge clk[0])
		noise <= ~noise;

	always_comb
		for (int p = 0; p < 2; p++)
		begin
			dataIn[p][17:9] = dataOeUpper[p] ? dataOut[p][17:9] :
				readNotWrite[p] ? noise[17:9] : wData[p][17:9];
			dataIn[p][8:0] = dataOeLower[p] ? dataOut[p][8:0] :
				readNotWrite[p] ? noise[8:0] : wData[p][8:0];
		end
endmodule

// ==== tb/tb_sdpr_port.sv ====
// Self-checking bench for the two-port RAM port logic.
// Assumes the masters model drives every port input of the block except clk and rstn.
`timescale 1ns/100ps
module tb_sdpr_port
	import sdpr_pkg::*;
;
	localparam logic [8:0] IDLE = 9'h0FE, LOAD = 9'h0F6, WRB = 9'h08E, WRU = 9'h09E;
	localparam logic [8:0] RDF = 9'h0C6, RDP = 9'h0C7, RDU = 9'h0D6, CLR = 9'h0C4;
	localparam logic [8:0] INC = 9'h0CA, HOLD = 9'h0CE, DINC = 9'h07A, DLD = 9'h076;
	localparam logic [8:0] BAD [3] = '{9'h00E, 9'h18E, 9'h0BE};
	localparam sdpr_data_t V1 = 18'h3_5A5A, V2 = 18'h0_1E1E;
	logic             clk = 1'b0, rstn = 1'b0;
	int               n_errors = 0, checked = 0;
	logic [1:0]       selectActiveLow, selectActiveHigh, readNotWrite, outputEnable_n;
	logic [1:0]       upperLaneSelect_n, lowerLaneSelect_n, addressLoadStrobe_n;
	logic [1:0]       incrementEnable_n, counterClear_n, outputLatencySelect;
	logic [1:0]       dataOeUpper, dataOeLower, standby;
	logic [1:0][15:0] addrIn;
	logic [1:0][17:0] dataIn, dataOut;

	sdpr_port i_sdpr_port (.clk, .rstn, .selectActiveLow, .selectActiveHigh, .readNotWrite,
		.outputEnable_n, .upperLaneSelect_n, .lowerLaneSelect_n, .addressLoadStrobe_n,
		.incrementEnable_n, .counterClear_n, .outputLatencySelect, .addrIn, .dataIn, .dataOut,
		.dataOeUpper, .dataOeLower, .standby);
	sdpr_masters i_sdpr_masters (.clk({1'b0, clk}), .dataOut, .dataOeUpper, .dataOeLower,
		.selectActiveLow, .selectActiveHigh, .readNotWrite, .outputEnable_n,
		.upperLaneSelect_n, .lowerLaneSelect_n, .addressLoadStrobe_n, .incrementEnable_n,
		.counterClear_n, .outputLatencySelect, .addrIn, .dataIn);

	always #25 clk = ~clk;

	task automatic chk(input sdpr_data_t seen, input sdpr_data_t exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Loads with read held high, then writes on the held address
	task automatic wr(input int p, input sdpr_addr_t a, input sdpr_data_t d, input logic [8:0] c);
		i_sdpr_masters.cyc(p, LOAD, a, 18'h0_0000);
		i_sdpr_masters.cyc(p, c, a, d);
		i_sdpr_masters.cyc(p, IDLE, a, 18'h0_0000);
	endtask

	// Idle keeps the latency bit so a pipelined answer is not cut short
	task automatic rd(input int p, input logic [8:0] c, input sdpr_addr_t a, input sdpr_data_t e,
		input logic [1:0] en);
		sdpr_data_t m;
		m = {{9{en[1]}}, {9{en[0]}}};
		i_sdpr_masters.cyc(p, c, a, 18'h0_0000);
		i_sdpr_masters.cyc(p, IDLE | (c & 9'h001), a, 18'h0_0000);
		#1 chk(18'(standby[p]), 18'h0_0000);
		@(posedge clk);
		if (c[0])
			@(posedge clk);
		#1 chk(18'({dataOeUpper[p], dataOeLower[p]}), 18'(en));
		chk(dataOut[p] & m, e & m);
	endtask

	task automatic t_dual;
		wr(0, 16'h1234, V1, WRB);
		fork
			rd(0, RDF, 16'h1234, V1, 2'h3);
			rd(1, RDP, 16'h1234, V1, 2'h3);
		join
		$display("t_dual done");
	endtask

	task automatic t_lanes;
		wr(1, 16'h1234, V2, WRU);
		rd(0, RDF, 16'h1234, {V2[17:9], V1[8:0]}, 2'h3);
		rd(0, RDU, 16'h1234, V2, 2'h2);
		$display("t_lanes done");
	endtask

	task automatic t_count;
		wr(1, 16'h0000, V1, WRB);
		wr(1, 16'h0001, V2, WRB);
		wr(1, 16'h0002, ~V1, WRB);
		wr(1, 16'hFFFF, ~V2, WRB);
		rd(1, RDF, 16'hFFFF, ~V2, 2'h3);
		rd(1, INC, 16'h1234, V1, 2'h3);
		rd(1, HOLD, 16'h1234, V1, 2'h3);
		i_sdpr_masters.cyc(1, DINC, 16'h1234, 18'h0_0000);
		rd(1, INC, 16'h1234, ~V1, 2'h3);
		i_sdpr_masters.cyc(1, DLD, 16'h0001, 18'h0_0000);
		rd(1, HOLD, 16'h1234, V2, 2'h3);
		rd(1, CLR, 16'h0001, V1, 2'h3);
		$display("t_count done");
	endtask

	task automatic t_desel;
		wr(0, 16'h0100, V1, WRB);
		for (int i = 0; i < 3; i++)
		begin
			i_sdpr_masters.cyc(0, BAD[i], 16'h0100, V2);
			i_sdpr_masters.cyc(0, IDLE, 16'h0100, 18'h0_0000);
			#1 chk(18'(standby[0]), 18'(i < 2));
		end
		rd(0, RDF, 16'h0100, V1, 2'h3);
		$display("t_desel done");
	endtask

	// Reads kept back to back so the registered enables stay high
	task automatic t_oe;
		i_sdpr_masters.cyc(0, RDF, 16'h0100, 18'h0_0000);
		i_sdpr_masters.cyc(0, HOLD, 16'h0100, 18'h0_0000);
		i_sdpr_masters.cyc(0, HOLD, 16'h0100, 18'h0_0000);
		#1 chk(18'({dataOeUpper[0], dataOeLower[0]}), 18'h0_0003);
		i_sdpr_masters.oe(0, 1'b1);
		#1 chk(18'({dataOeUpper[0], dataOeLower[0]}), 18'h0_0000);
		i_sdpr_masters.oe(0, 1'b0);
		#1 chk(18'({dataOeUpper[0], dataOeLower[0]}), 18'h0_0003);
		i_sdpr_masters.cyc(0, IDLE, 16'h0100, 18'h0_0000);
		$display("t_oe done");
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_dual;
		t_lanes;
		t_count;
		t_desel;
		t_oe;
		test_done;
	end

	initial
	begin
		#50000;
		n_errors++;
		test_done;
	end
endmodule
